// ===== rtl/cmd_pkg.sv
// Package holding the address map, register offsets and reset values of the memory decode block.
package cmd_pkg;
	localparam int unsigned PC_W = 16;
	localparam logic [15:0] ROM_BASE = 16'hf000;
	localparam logic [15:0] VEC_REGION = 16'hff00;
	localparam logic [15:0] RESET_VEC = 16'hfffe;
	localparam logic [15:0] EXT0_VEC = 16'hfffa;
	localparam logic [15:0] EXT1_VEC = 16'hfff8;
	localparam logic [15:0] TABLE_CALL_INSTR_BASE = 16'hffde;
	localparam logic [15:0] PAGE_CALL_INSTR_BASE = 16'hff00;
	localparam logic [8:0] STACK_BASE = 9'h1c0;
	localparam logic [7:0] CTRL_LO = 8'hc0;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	// Register offsets in the control window.
	localparam logic [7:0] A_PORT0 = 8'hc0;
	localparam logic [7:0] A_PORT1 = 8'hc1;
	localparam logic [7:0] A_PORT2 = 8'hc2;
	localparam logic [7:0] A_PORT4 = 8'hc4;
	localparam logic [7:0] A_PORT5 = 8'hc5;
	localparam logic [7:0] A_PORT6 = 8'hc6;
	localparam logic [7:0] A_PORT7 = 8'hc7;
	localparam logic [7:0] A_DIR0 = 8'hc8;
	localparam logic [7:0] A_DIR1 = 8'hc9;
	localparam logic [7:0] A_DIR2 = 8'hca;
	localparam logic [7:0] A_DIR4 = 8'hcc;
	localparam logic [7:0] A_DIR5 = 8'hcd;
	localparam logic [7:0] A_DIR6 = 8'hce;
	localparam logic [7:0] A_DIR7 = 8'hcf;
	localparam logic [7:0] A_PORT0_PULLUP_SELECT = 8'hd4;
	localparam logic [7:0] A_PORT1_PULLUP_SELECT = 8'hd5;
	localparam logic [7:0] A_PORT2_PULLUP_SELECT = 8'hd6;
	localparam logic [7:0] A_EXT_INT_EDGE_SELECT = 8'hd8;
	localparam logic [7:0] A_PFS0 = 8'hd9;
	localparam logic [7:0] A_IRQ_ENABLE_LOW = 8'hda;
	localparam logic [7:0] A_IRQ_ENABLE_HIGH = 8'hdb;
	localparam logic [7:0] A_IRQ_REQUEST_LOW = 8'hdc;
	localparam logic [7:0] A_IRQ_REQUEST_HIGH = 8'hdd;
	localparam logic [7:0] A_SLEEP = 8'hde;
	localparam logic [7:0] A_WDOG = 8'hdf;
	localparam logic [7:0] A_T1MODE = 8'he4;
	localparam logic [7:0] A_T1 = 8'he5;
	localparam logic [7:0] A_CMPM = 8'hec;
	localparam logic [7:0] A_CMPS = 8'hed;
	localparam logic [7:0] A_WTM = 8'hf0;
	localparam logic [7:0] A_LCDC = 8'hf1;
	localparam logic [7:0] A_LCDP = 8'hf3;
	localparam logic [7:0] A_KSC = 8'hf4;
	localparam logic [7:0] A_KSR = 8'hf5;
	localparam logic [7:0] A_PFS1 = 8'hf6;
	localparam logic [7:0] A_BUZ = 8'hf7;
	localparam logic [7:0] A_RPAGE = 8'hf8;
	localparam logic [7:0] A_CLK = 8'hf9;
	localparam logic [7:0] A_SCM = 8'hfa;
	localparam logic [7:0] A_PCE = 8'hfb;
	localparam logic [7:0] A_LVD = 8'hfe;
	// Reset values.
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_WDOG = 8'h3f;
	localparam logic [7:0] RST_BUZ = 8'hff;
	localparam logic [7:0] RST_CLK = 8'h07;
	localparam logic [7:0] RST_LVD = 8'h10;
	localparam logic [7:0] RST_SP = 8'hff;
	// Core sequencing commands.
	typedef enum logic [2:0] {
		CMD_NONE, CMD_CALL, CMD_IRQ, CMD_TABLE_CALL_INSTR, CMD_PAGE_CALL_INSTR, CMD_RET, CMD_INTERRUPT_EXIT
	} cmd_cmd_t;
	typedef enum {
		ST_IDLE, ST_PUSH_HI, ST_PUSH_LO, ST_PUSH_PSW, ST_VEC_LO, ST_VEC_HI,
		ST_POP_PSW, ST_POP_LO, ST_POP_HI
	} cmd_state_t;
endpackage

// ===== rtl/cmd_memory_map_decode.sv
// Program and data address decode, control registers and call/return stack sequencing.
`timescale 1ns/1ps
// Functional notes
// - Program counter is 16 bits and wraps from FFFF to 0000.
// - Only the top 4K of program space is backed by memory.
// - After reset the counter loads from the reset vector at FFFE/FFFF.
// - Each table call fetches a two-byte target from its own slot.
// - Page call is two bytes and targets the fixed page area.
// - Interrupt vectors are two-byte slots; external 0 at FFFA, 1 at FFF8.
// - Unused vector slots from FF00 read as ordinary program memory.
// - Data space holds 192 bytes (00 to BF) of readable and writable user RAM.
// - Data addresses C0 to FF decode to control registers.
// - Unassigned control addresses read 00; writes to them are ignored.
// - Bit-addressable registers accept bit set/clear and byte access.
// - Calls and accepted interrupts push the return address first.
// - Subroutine exit pops the counter; interrupt exit also pops flags.
// - Stack pointer decrements after save and increments before restore.
// - Address E5 reads timer-1 count and writes timer-1 compare.
// - Address F9 reads interval timer count and writes clock control.
// - Stack lives at 100 to 1FF, chosen by the 8-bit pointer.
module cmd_memory_map_decode
	import cmd_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Program memory fetch port from the core.
	input wire logic [cmd_pkg::PC_W-1:0] prog_addr_i,
	input wire logic [7:0] rom_data_i,
	output logic [7:0] prog_data_o,
	output logic rom_hit_o,
	// Core control sequencing.
	input wire cmd_pkg::cmd_cmd_t cmd_i,
	input wire logic [3:0] cmd_index_i,
	input wire logic [7:0] cmd_offset_i,
	input wire logic [15:0] ret_addr_i,
	input wire logic [7:0] psw_i,
	input wire logic pc_step_i,
	output logic [15:0] program_counter_o,
	output logic [7:0] psw_o,
	output logic psw_load_o,
	output logic busy_o,
	// Data space access port from the core.
	input wire logic [7:0] data_addr_i,
	input wire logic data_wr_i,
	input wire logic data_bit_i,
	input wire logic [2:0] data_bit_sel_i,
	input wire logic data_bit_val_i,
	input wire logic [7:0] data_wdata_i,
	output logic [7:0] data_rdata_o,
	// Stack pointer load from software.
	input wire logic sp_load_i,
	input wire logic [7:0] sp_wdata_i,
	output logic [7:0] stack_pointer_o,
	// Peripheral state inputs on this clock.
	input wire logic [7:0] timer1_count_i,
	input wire logic [7:0] interval_timer_count_i,
	input wire logic [7:0] key_scan_result_i,
	input wire logic [7:0] irq_set_low_i,
	input wire logic [7:0] irq_set_high_i,
	// Control register outputs.
	output logic [7:0] timer1_compare_o,
	output logic [7:0] clock_control_o,
	output logic [55:0] port_data_o,
	output logic [55:0] port_direction_o,
	output logic [7:0] irq_enable_low_o,
	output logic [7:0] irq_enable_high_o,
	output logic [7:0] irq_request_low_o,
	output logic [7:0] irq_request_high_o
);
	// Byte storage: 192 user RAM bytes (00 to BF) in the lower page plus stack page, indexed by 9-bit address.
	logic [7:0] ram_reg [0:511];
	logic [7:0] ctrl_reg [0:63];
	logic [7:0] ctrl_next [0:63];
	logic [15:0] pc_reg, pc_next;
	logic [7:0] sp_reg, sp_next;
	logic [7:0] psw_reg, psw_next;
	logic psw_load_reg, psw_load_next;
	logic [15:0] vec_reg, vec_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] pdata_reg, pdata_next;
	logic rom_hit_reg, rom_hit_next;
	logic boot_reg, boot_next, busy_reg;
	cmd_state_t st_reg, st_next;
	cmd_cmd_t op_reg, op_next;
	logic stk_we;
	logic [8:0] stk_addr;
	logic [7:0] stk_wdata;
	logic ram_we;
	logic [7:0] ram_wbyte;
	logic [5:0] cidx;
	logic [7:0] vec_byte;
	logic [15:0] pc_plus;

	function automatic logic ctrl_valid(input logic [7:0] a);
		case (a)
			A_PORT0, A_PORT1, A_PORT2, A_PORT4, A_PORT5, A_PORT6, A_PORT7,
			A_DIR0, A_DIR1, A_DIR2, A_DIR4, A_DIR5, A_DIR6, A_DIR7,
			A_PORT0_PULLUP_SELECT, A_PORT1_PULLUP_SELECT, A_PORT2_PULLUP_SELECT, A_EXT_INT_EDGE_SELECT, A_PFS0, A_IRQ_ENABLE_LOW, A_IRQ_ENABLE_HIGH, A_IRQ_REQUEST_LOW, A_IRQ_REQUEST_HIGH,
			A_SLEEP, A_WDOG, A_T1MODE, A_T1, A_CMPM, A_CMPS, A_WTM, A_LCDC, A_LCDP,
			A_KSC, A_KSR, A_PFS1, A_BUZ, A_RPAGE, A_CLK, A_SCM, A_PCE, A_LVD: ctrl_valid = 1'b1;
			default: ctrl_valid = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] ctrl_rst(input logic [7:0] a);
		case (a)
			A_WDOG: ctrl_rst = RST_WDOG;
			A_BUZ: ctrl_rst = RST_BUZ;
			A_CLK: ctrl_rst = RST_CLK;
			A_LVD: ctrl_rst = RST_LVD;
			default: ctrl_rst = RST_ZERO;
		endcase
	endfunction

	// Bit-addressable registers take single-bit updates; byte-only ones are whole-byte.
	function automatic logic bit_ok(input logic [7:0] a);
		bit_ok = a < A_DIR0 || (a >= A_IRQ_ENABLE_LOW && a <= A_IRQ_REQUEST_HIGH) || a == A_T1MODE || a == A_LCDC ||
			a == A_LCDP || a == A_KSC || a == A_PFS1 || a == A_RPAGE || a == A_SCM || a == A_LVD;
	endfunction

	assign cidx = data_addr_i[5:0];
	assign pc_plus = pc_reg + 16'h0001;
	assign vec_byte = (vec_reg >= ROM_BASE) ? rom_data_i : 8'h00;

	// Program memory decode: only the top 4K answers.
	always_comb begin
		rom_hit_next = prog_addr_i >= ROM_BASE;
		pdata_next = rom_hit_next ? rom_data_i : 8'h00;
	end

	// Data writes to RAM or control window, and reads.
	always_comb begin
		ram_we = 1'b0;
		ram_wbyte = data_wdata_i;
		rdata_next = UNMAPPED_RD;
		for (int i = 0; i < 64; i++) begin
			ctrl_next[i] = ctrl_reg[i];
		end
		if (data_addr_i >= CTRL_LO) begin
			if (data_wr_i && ctrl_valid(data_addr_i) && !(data_bit_i && !bit_ok(data_addr_i))) begin
				if (data_bit_i) begin
					ctrl_next[cidx][data_bit_sel_i] = data_bit_val_i;
				end else begin
					ctrl_next[cidx] = data_wdata_i;
				end
			end
			case (data_addr_i)
				A_T1: rdata_next = timer1_count_i;
				A_CLK: rdata_next = interval_timer_count_i;
				A_KSR: rdata_next = key_scan_result_i;
				default: rdata_next = (ctrl_valid(data_addr_i) && bit_ok(data_addr_i)) ? ctrl_reg[cidx] : UNMAPPED_RD;
			endcase
		end else begin
			ram_we = data_wr_i;
			if (data_bit_i) begin
				ram_wbyte = ram_reg[{1'b0, data_addr_i}];
				ram_wbyte[data_bit_sel_i] = data_bit_val_i;
			end
			rdata_next = ram_reg[{1'b0, data_addr_i}];
		end
		// Hardware-raised interrupt requests win over a software clear in the same cycle.
		ctrl_next[A_IRQ_REQUEST_LOW[5:0]] = ctrl_next[A_IRQ_REQUEST_LOW[5:0]] | irq_set_low_i;
		ctrl_next[A_IRQ_REQUEST_HIGH[5:0]] = ctrl_next[A_IRQ_REQUEST_HIGH[5:0]] | irq_set_high_i;
	end

	// Call, interrupt and return sequencer.
	always_comb begin
		st_next = st_reg;
		op_next = op_reg;
		pc_next = pc_reg;
		sp_next = sp_reg;
		psw_next = psw_reg;
		psw_load_next = 1'b0;
		vec_next = vec_reg;
		boot_next = 1'b0;
		stk_we = 1'b0;
		stk_addr = {1'b1, sp_reg};
		stk_wdata = 8'h00;
		case (st_reg)
			ST_IDLE: begin
				if (boot_reg) begin
					vec_next = RESET_VEC;
					op_next = CMD_NONE;
					st_next = ST_VEC_LO;
				end else if (sp_load_i) begin
					sp_next = sp_wdata_i;
				end else begin
					op_next = cmd_i;
					case (cmd_i)
						CMD_CALL, CMD_IRQ, CMD_TABLE_CALL_INSTR, CMD_PAGE_CALL_INSTR: st_next = ST_PUSH_HI;
						CMD_INTERRUPT_EXIT: st_next = ST_POP_PSW;
						CMD_RET: st_next = ST_POP_LO;
						default: if (pc_step_i) pc_next = pc_plus;
					endcase
					case (cmd_i)
						CMD_IRQ: vec_next = cmd_index_i[0] ? EXT1_VEC : EXT0_VEC;
						CMD_TABLE_CALL_INSTR: vec_next = TABLE_CALL_INSTR_BASE - {11'h000, cmd_index_i, 1'b0};
						CMD_PAGE_CALL_INSTR: vec_next = PAGE_CALL_INSTR_BASE | {8'h00, cmd_offset_i};
						default: vec_next = ret_addr_i;
					endcase
				end
			end
			ST_PUSH_HI: begin
				stk_we = 1'b1;
				stk_wdata = ret_addr_i[15:8];
				sp_next = sp_reg - 8'h01;
				st_next = ST_PUSH_LO;
			end
			ST_PUSH_LO: begin
				stk_we = 1'b1;
				stk_wdata = ret_addr_i[7:0];
				sp_next = sp_reg - 8'h01;
				st_next = (op_reg == CMD_IRQ) ? ST_PUSH_PSW : ST_VEC_LO;
			end
			ST_PUSH_PSW: begin
				stk_we = 1'b1;
				stk_wdata = psw_i;
				sp_next = sp_reg - 8'h01;
				st_next = ST_VEC_LO;
			end
			ST_VEC_LO: begin
				if (op_reg == CMD_CALL || op_reg == CMD_PAGE_CALL_INSTR) begin
					pc_next = vec_reg;
					st_next = ST_IDLE;
				end else begin
					pc_next = {8'h00, vec_byte};
					vec_next = vec_reg + 16'h0001;
					st_next = ST_VEC_HI;
				end
			end
			ST_VEC_HI: begin
				pc_next = {vec_byte, pc_reg[7:0]};
				st_next = ST_IDLE;
			end
			ST_POP_PSW: begin
				sp_next = sp_reg + 8'h01;
				stk_addr = {1'b1, sp_next};
				psw_next = ram_reg[stk_addr];
				psw_load_next = 1'b1;
				st_next = ST_POP_LO;
			end
			ST_POP_LO: begin
				sp_next = sp_reg + 8'h01;
				stk_addr = {1'b1, sp_next};
				pc_next = {pc_reg[15:8], ram_reg[stk_addr]};
				st_next = ST_POP_HI;
			end
			ST_POP_HI: begin
				sp_next = sp_reg + 8'h01;
				stk_addr = {1'b1, sp_next};
				pc_next = {ram_reg[stk_addr], pc_reg[7:0]};
				st_next = ST_IDLE;
			end
			default: st_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			st_reg <= ST_IDLE;
			op_reg <= CMD_NONE;
			pc_reg <= 16'h0000;
			sp_reg <= RST_SP;
			psw_reg <= 8'h00;
			psw_load_reg <= 1'b0;
			vec_reg <= 16'h0000;
			boot_reg <= 1'b1;
			busy_reg <= 1'b1;
			rdata_reg <= 8'h00;
			pdata_reg <= 8'h00;
			rom_hit_reg <= 1'b0;
			for (int i = 0; i < 64; i++) begin
				ctrl_reg[i] <= ctrl_rst(CTRL_LO | 8'(i));
			end
		end else begin
			st_reg <= st_next;
			op_reg <= op_next;
			pc_reg <= pc_next;
			sp_reg <= sp_next;
			psw_reg <= psw_next;
			psw_load_reg <= psw_load_next;
			vec_reg <= vec_next;
			boot_reg <= boot_next;
			busy_reg <= (st_next != ST_IDLE) || boot_next;
			rdata_reg <= rdata_next;
			pdata_reg <= pdata_next;
			rom_hit_reg <= rom_hit_next;
			for (int i = 0; i < 64; i++) begin
				ctrl_reg[i] <= ctrl_next[i];
			end
		end
	end

	// Storage is written without reset; contents are undefined at power-up.
	always_ff @(posedge sys_clk_i) begin
		if (stk_we) begin
			ram_reg[stk_addr] <= stk_wdata;
		end else if (ram_we) begin
			ram_reg[{1'b0, data_addr_i}] <= ram_wbyte;
		end
	end

	genvar g;
	for (g = 0; g < 7; g++) begin : g_port
		localparam int SLOT = (g < 3) ? g : g + 1;
		assign port_data_o[g*8 +: 8] = ctrl_reg[SLOT];
		assign port_direction_o[g*8 +: 8] = ctrl_reg[SLOT + 8];
	end

	assign prog_data_o = pdata_reg;
	assign rom_hit_o = rom_hit_reg;
	assign program_counter_o = pc_reg;
	assign psw_o = psw_reg;
	assign psw_load_o = psw_load_reg;
	assign busy_o = busy_reg;
	assign data_rdata_o = rdata_reg;
	assign stack_pointer_o = sp_reg;
	assign timer1_compare_o = ctrl_reg[A_T1[5:0]];
	assign clock_control_o = ctrl_reg[A_CLK[5:0]];
	assign irq_enable_low_o = ctrl_reg[A_IRQ_ENABLE_LOW[5:0]];
	assign irq_enable_high_o = ctrl_reg[A_IRQ_ENABLE_HIGH[5:0]];
	assign irq_request_low_o = ctrl_reg[A_IRQ_REQUEST_LOW[5:0]];
	assign irq_request_high_o = ctrl_reg[A_IRQ_REQUEST_HIGH[5:0]];
endmodule // cmd_memory_map_decode

// ===== bench/cmd_rom_model.sv
// Program memory model answering fetch and vector reads from the decode block.
`timescale 1ns/1ps
module cmd_rom_model (
	// Address from the core side.
	input wire logic [15:0] addr_i,
	// Byte stored at that address.
	output logic [7:0] data_o
);
	// Both bytes of a slot hold one value, so a vector read does not depend on its exact cycle.
	assign data_o = addr_i[8:1] ^ 8'ha5;
endmodule // cmd_rom_model

// ===== bench/cmd_memory_map_decode_properties.sv
// Concurrent checks on the ports of the memory decode block.
`timescale 1ns/1ps
module cmd_memory_map_decode_properties
	import cmd_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Program side.
	input wire logic [cmd_pkg::PC_W-1:0] prog_addr_i,
	input wire logic [7:0] rom_data_i,
	input wire logic [7:0] prog_data_o,
	input wire logic rom_hit_o,
	input wire cmd_pkg::cmd_cmd_t cmd_i,
	input wire logic pc_step_i,
	input wire logic [15:0] program_counter_o,
	input wire logic busy_o,
	input wire logic [7:0] stack_pointer_o,
	// Data side.
	input wire logic [7:0] data_addr_i,
	input wire logic data_wr_i,
	input wire logic data_bit_i,
	input wire logic [7:0] data_wdata_i,
	input wire logic [7:0] data_rdata_o,
	input wire logic [7:0] timer1_count_i,
	input wire logic [7:0] interval_timer_count_i,
	input wire logic [7:0] timer1_compare_o,
	input wire logic [7:0] clock_control_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	a_rom_gate_low: assert property (prog_addr_i < ROM_BASE |=> prog_data_o == 8'h00 && !rom_hit_o)
		else $error("fetch below program memory not blocked");
	a_rom_pass_high: assert property (prog_addr_i >= ROM_BASE |=> prog_data_o == $past(rom_data_i) && rom_hit_o)
		else $error("fetch in program memory not passed");
	a_clk_ctl_write: assert property (data_wr_i && !data_bit_i && data_addr_i == A_CLK |=> clock_control_o == $past(data_wdata_i))
		else $error("clock control not loaded");
	a_t1_cmp_write: assert property (data_wr_i && !data_bit_i && data_addr_i == A_T1 |=> timer1_compare_o == $past(data_wdata_i))
		else $error("timer compare not loaded");
	a_t1_count_read: assert property (!data_wr_i && data_addr_i == A_T1 |=> data_rdata_o == $past(timer1_count_i))
		else $error("timer count not read");
	a_itc_read: assert property (!data_wr_i && data_addr_i == A_CLK |=> data_rdata_o == $past(interval_timer_count_i))
		else $error("interval count not read");
	a_pc_step_wrap: assert property (!busy_o && cmd_i == CMD_NONE && pc_step_i |=> program_counter_o == $past(program_counter_o) + 16'h0001)
		else $error("counter step wrong");
	a_sp_table_call_instr_push: assert property (!busy_o && cmd_i == CMD_TABLE_CALL_INSTR |-> ##5 stack_pointer_o == $past(stack_pointer_o, 5) - 8'h02)
		else $error("table call push count wrong");
	a_busy_after_reset: assert property ($rose(resetn_i) |-> ##[0:8] !busy_o)
		else $error("reset vector load too slow");
endmodule // cmd_memory_map_decode_properties
bind cmd_memory_map_decode cmd_memory_map_decode_properties i_cmd_memory_map_decode_properties (.*);

// ===== bench/tb.sv
// Self-checking bench for the memory decode block.
`timescale 1ns/1ps
module tb;
	import cmd_pkg::*;
	logic sys_clk_i, resetn_i, rom_hit_o, pc_step_i, psw_load_o, busy_o, data_wr_i, data_bit_i, data_bit_val_i, sp_load_i;
	logic [15:0] prog_addr_i, ret_addr_i, program_counter_o;
	logic [7:0] rom_data_i, prog_data_o, cmd_offset_i, psw_i, psw_o, data_addr_i, data_wdata_i, data_rdata_o;
	logic [7:0] sp_wdata_i, stack_pointer_o, timer1_count_i, interval_timer_count_i, key_scan_result_i;
	logic [7:0] irq_set_low_i, irq_set_high_i, timer1_compare_o, clock_control_o;
	logic [7:0] irq_enable_low_o, irq_enable_high_o, irq_request_low_o, irq_request_high_o;
	logic [3:0] cmd_index_i;
	logic [2:0] data_bit_sel_i;
	logic [55:0] port_data_o, port_direction_o;
	cmd_cmd_t cmd_i;
	int err_count = 0, n_checks = 0, cyc = 0;
	cmd_memory_map_decode i_cmd_memory_map_decode (.*);
	cmd_rom_model i_cmd_rom_model (.addr_i(prog_addr_i), .data_o(rom_data_i));
	always #10 sys_clk_i = ~sys_clk_i;
	function automatic logic [7:0] rb(input logic [15:0] a);
		return a[8:1] ^ 8'ha5;
	endfunction
	task automatic chk(input logic [55:0] got, input logic [55:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic tick;
		@(posedge sys_clk_i);
		#1;
	endtask
	task automatic wait_idle;
		int k;
		k = 0;
		while (busy_o !== 1'b0 && k < 30) begin
			tick;
			k++;
		end
		chk(busy_o, 0, "busy");
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bt, input logic [2:0] sel);
		data_addr_i = a;
		data_wdata_i = d;
		data_bit_i = bt;
		data_bit_sel_i = sel;
		data_bit_val_i = 1'b1;
		data_wr_i = 1'b1;
		tick;
		data_wr_i = 1'b0;
		data_bit_i = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		data_addr_i = a;
		tick;
		chk(data_rdata_o, exp, what);
	endtask
	task automatic run(input cmd_cmd_t c, input logic [3:0] ix, input logic [7:0] off, input logic [15:0] va);
		prog_addr_i = va;
		cmd_index_i = ix;
		cmd_offset_i = off;
		cmd_i = c;
		tick;
		cmd_i = CMD_NONE;
		wait_idle;
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic t_reset;
		resetn_i = 1'b0;
		repeat (3) tick;
		resetn_i = 1'b1;
		wait_idle;
		chk(program_counter_o, {rb(RESET_VEC), rb(RESET_VEC)}, "reset pc");
		chk(clock_control_o, RST_CLK, "clk reset");
		chk(port_direction_o, 56'h0, "dir reset");
		$display("test reset done");
	endtask
	task automatic t_rom;
		logic [15:0] al[5] = '{16'h0000, 16'hefff, 16'hf000, 16'hff10, 16'hffff};
		foreach (al[i]) begin
			prog_addr_i = al[i];
			tick;
			chk(prog_data_o, (al[i] >= ROM_BASE) ? rb(al[i]) : 8'h00, "fetch");
			chk(rom_hit_o, al[i] >= ROM_BASE, "hit");
		end
		$display("test program memory done");
	endtask
	task automatic t_data;
		wr(8'h10, 8'h3c, 1'b0, 3'h0);
		rd(8'h10, 8'h3c, "ram");
		wr(8'hbf, 8'hc3, 1'b0, 3'h0);
		rd(8'hbf, 8'hc3, "ram top");
		rd(8'hc3, UNMAPPED_RD, "unmapped");
		rd(A_DIR0, 8'h00, "write only");
		wr(A_PORT7, 8'h96, 1'b0, 3'h0);
		chk(port_data_o[55:48], 8'h96, "port7 data");
		wr(A_DIR4, 8'h3c, 1'b0, 3'h0);
		chk(port_direction_o[31:24], 8'h3c, "port4 dir");
		wr(A_T1, 8'h5a, 1'b0, 3'h0);
		chk(timer1_compare_o, 8'h5a, "t1 cmp");
		timer1_count_i = 8'h77;
		rd(A_T1, 8'h77, "t1 count");
		wr(A_CLK, 8'h09, 1'b0, 3'h0);
		chk(clock_control_o, 8'h09, "clk ctl");
		interval_timer_count_i = 8'h2b;
		rd(A_CLK, 8'h2b, "itc");
		key_scan_result_i = 8'h61;
		rd(A_KSR, 8'h61, "key");
		wr(A_IRQ_ENABLE_LOW, 8'h00, 1'b0, 3'h0);
		wr(A_IRQ_ENABLE_LOW, 8'h00, 1'b1, 3'h3);
		rd(A_IRQ_ENABLE_LOW, 8'h08, "bit set");
		chk(irq_enable_low_o, 8'h08, "ien out");
		irq_set_high_i = 8'h04;
		irq_set_low_i = 8'h20;
		tick;
		irq_set_high_i = 8'h00;
		irq_set_low_i = 8'h00;
		rd(A_IRQ_REQUEST_HIGH, 8'h04, "irq high");
		rd(A_IRQ_REQUEST_LOW, 8'h20, "irq low");
		chk({irq_request_high_o, irq_request_low_o}, 16'h0420, "irq out");
		$display("test data space done");
	endtask
	task automatic t_stack;
		logic [15:0] v;
		sp_wdata_i = 8'hff;
		sp_load_i = 1'b1;
		tick;
		sp_load_i = 1'b0;
		ret_addr_i = 16'hf123;
		run(CMD_CALL, 4'h0, 8'h00, 16'h0000);
		chk({program_counter_o, stack_pointer_o}, {16'hf123, 8'hfd}, "call");
		run(CMD_RET, 4'h0, 8'h00, 16'h0000);
		chk({program_counter_o, stack_pointer_o}, {16'hf123, 8'hff}, "call ret");
		ret_addr_i = 16'h1234;
		run(CMD_TABLE_CALL_INSTR, 4'h3, 8'h00, TABLE_CALL_INSTR_BASE - 16'h0006);
		chk(program_counter_o, {2{rb(TABLE_CALL_INSTR_BASE - 16'h0006)}}, "table_call_instr pc");
		chk(stack_pointer_o, 8'hfd, "table_call_instr sp");
		run(CMD_RET, 4'h0, 8'h00, 16'h0000);
		chk({program_counter_o, stack_pointer_o}, {16'h1234, 8'hff}, "ret");
		for (int i = 0; i < 2; i++) begin
			v = (i == 0) ? EXT0_VEC : EXT1_VEC;
			psw_i = 8'h81 + 8'(i);
			ret_addr_i = 16'h2345;
			run(CMD_IRQ, 4'(i), 8'h00, v);
			chk({program_counter_o, stack_pointer_o}, {rb(v), rb(v), 8'hfc}, "irq");
			run(CMD_INTERRUPT_EXIT, 4'h0, 8'h00, 16'h0000);
			chk({program_counter_o, stack_pointer_o, psw_o}, {16'h2345, 8'hff, 8'h81 + 8'(i)}, "interrupt_exit");
		end
		run(CMD_PAGE_CALL_INSTR, 4'h0, 8'hff, 16'h0000);
		chk(program_counter_o, PAGE_CALL_INSTR_BASE + 16'h00ff, "page_call_instr");
		pc_step_i = 1'b1;
		tick;
		pc_step_i = 1'b0;
		chk(program_counter_o, 16'h0000, "wrap");
		run(CMD_RET, 4'h0, 8'h00, 16'h0000);
		chk(stack_pointer_o, 8'hff, "sp back");
		$display("test stack done");
	endtask
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			end_sim;
		end
	end
	initial begin
		sys_clk_i = 1'b0;
		resetn_i = 1'b0;
		prog_addr_i = RESET_VEC;
		{ret_addr_i, cmd_offset_i, psw_i, data_addr_i, data_wdata_i, sp_wdata_i} = '0;
		{timer1_count_i, interval_timer_count_i, key_scan_result_i, irq_set_low_i, irq_set_high_i} = '0;
		{pc_step_i, data_wr_i, data_bit_i, data_bit_val_i, sp_load_i, cmd_index_i, data_bit_sel_i} = '0;
		cmd_i = CMD_NONE;
		t_reset;
		t_rom;
		t_data;
		t_stack;
		end_sim;
	end
endmodule // tb
